// ==== common/dmsp_defines.vh ====
// Constants for the dual mode serial port: offsets, fields, codes, counts
// Operation
// - Clock-synchronous mode moves fixed 8-bit characters, buffer bits 0 to 7.
// - Internal synchronous clock is prescaled clock over 2*(divider+1).
// - Polarity 0 shifts out on falling, samples on rising; 1 reverses.
// - Bit order 0 sends bit 0 first, 1 sends bit 7 first.
// - Synchronous overrun when 7th bit arrives before previous character read.
// - Overrun leaves buffer undefined and raises no receive interrupt.
// - Output pin high from mode selection until first transfer; open-drain floats.
// - Receive-only synchronous use still shifts dummy transmit data out.
// - Continuous receive: reading receive buffer clears transmit buffer empty flag.
// - UART frame: one start bit then 7, 8 or 9 character bits.
// - UART appends odd, even or no parity after character bits.
// - UART frame ends with one or two stop bits.
// - UART internal bit clock is prescaled clock over 16*(divider+1).
// - UART external bit clock is pin frequency over 16*(divider+1).
// - Transmission starts only with transmit enabled and transmit buffer full.
// - UART reception starts only with receive enabled and start bit seen.
// - Transmit interrupt at buffer-to-shift move, or at shift end, by select.
// - Receive interrupt and done flag when character moves into receive buffer.
// - UART overrun when bit before final stop arrives with previous unread.
// - Framing error when configured stop bits are missing.
// - Parity error when ones count mismatches configured odd or even.
// - Error summary flag set by any overrun, framing or parity error.
`ifndef DMSP_DEFINES_VH
`define DMSP_DEFINES_VH
`define DMSP_OFF_TXB     8'h00
`define DMSP_OFF_RXB     8'h04
`define DMSP_OFF_BRG     8'h08
`define DMSP_OFF_MODE    8'h0C
`define DMSP_OFF_CTLA    8'h10
`define DMSP_OFF_CTLB    8'h14
`define DMSP_OFF_SHARED  8'h18
`define DMSP_MODE_OFF    3'h0
`define DMSP_MODE_SYNC   3'h1
`define DMSP_MODE_UART7  3'h4
`define DMSP_MODE_UART8  3'h5
`define DMSP_MODE_UART9  3'h6
`define DMSP_MR_EXT      3
`define DMSP_MR_STOP2    4
`define DMSP_MR_EVEN     5
`define DMSP_MR_PAREN    6
`define DMSP_CA_PRE_LO   0
`define DMSP_CA_PRE_HI   1
`define DMSP_CA_TX_SHIFT_EMPTY    3
`define DMSP_CA_NCH      5
`define DMSP_CA_POL      6
`define DMSP_CA_ORDER    7
`define DMSP_CB_TE       0
`define DMSP_CB_TI       1
`define DMSP_CB_RE       2
`define DMSP_CB_RI       3
`define DMSP_SH_IRS      0
`define DMSP_SH_RRM      2
`define DMSP_RB_OVR      12
`define DMSP_RB_FER      13
`define DMSP_RB_PER      14
`define DMSP_RB_SUM      15
`define DMSP_PRE_F1      2'h0
`define DMSP_PRE_F8      2'h1
`define DMSP_PRE_F8_MASK 5'h07
`define DMSP_PRE_F32_MAX 5'h1F
`define DMSP_OS_MID      4'h7
`define DMSP_OS_LAST     4'hF
`define DMSP_SYNC_LAST   3'h7
`define DMSP_SYNC_OVR    3'h6
`define DMSP_LEN7        4'h7
`define DMSP_LEN8        4'h8
`define DMSP_LEN9        4'h9
`define DMSP_ONE         4'h1
`define DMSP_TWO         4'h2
`endif

// ==== src/dmsp_brg.v ====
// Prescaler and bit rate divider for the dual mode serial port
`timescale 1ns/10ps
`include "dmsp_defines.vh"
module dmsp_brg (
  input  wire       ref_clk,
  input  wire       rst,
  input  wire [1:0] prescale_sel,
  input  wire       use_ext,
  input  wire       ext_edge,
  input  wire [7:0] divider,
  output reg        tick
);
  reg  [4:0] pre_cnt;
  reg  [7:0] div_cnt;
  wire       src_tick;

  // Count source: f1, f8, f32 or the external pin edges
  assign src_tick = use_ext ? ext_edge :
                    (prescale_sel == `DMSP_PRE_F1) ? 1'b1 :
                    (prescale_sel == `DMSP_PRE_F8) ?
                      ((pre_cnt & `DMSP_PRE_F8_MASK) == `DMSP_PRE_F8_MASK) :
                      (pre_cnt == `DMSP_PRE_F32_MAX);

  // Free-running prescaler
  always @(posedge ref_clk) begin
    if (rst) begin
      pre_cnt <= 5'h00;
    end else begin
      pre_cnt <= pre_cnt + 5'h01;
    end
  end

  // Divide count source by divider plus one
  always @(posedge ref_clk) begin
    if (rst) begin
      div_cnt <= 8'h00;
      tick    <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (src_tick) begin
        if (div_cnt == 8'h00) begin
          div_cnt <= divider;
          tick    <= 1'b1;
        end else begin
          div_cnt <= div_cnt - 8'h01;
        end
      end
    end
  end
endmodule // dmsp_brg

// ==== src/dmsp_top.v ====
// Dual mode serial port: AHB-Lite registers, synchronous and UART engines
//
// Local design decisions: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "dmsp_defines.vh"
module dmsp_top (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire        serial_in_pin,
  output wire        serial_out_pin_o,
  output wire        serial_out_pin_oe,
  input  wire        transfer_clock_pin_i,
  output wire        transfer_clock_pin_o,
  output wire        transfer_clock_pin_oe,
  output reg         tx_int,
  output reg         rx_int
);
  localparam R_IDLE  = 2'h0;
  localparam R_START = 2'h1;
  localparam R_BITS  = 2'h2;

  // Register contents
  reg  [8:0]  tx_buffer;
  reg  [8:0]  rx_buffer;
  reg  [7:0]  bit_rate_divider;
  reg  [7:0]  serial_mode;
  reg  [1:0]  baud_prescale_sel;
  reg         txd_open_drain_sel;
  reg         edge_polarity_sel;
  reg         bit_order_sel;
  reg         transmit_enable;
  reg         rx_on;
  reg         tx_buffer_empty_flag;
  reg         rx_done_flag;
  reg         tx_int_source_sel;
  reg         continuous_rx_en;
  reg         overrun_flag;
  reg         framing_flag;
  reg         parity_flag;
  // Bus data phase
  reg         d_wr;
  reg  [7:0]  d_addr;
  reg  [31:0] rd_mux;
  // Engines
  reg         txd;
  reg         sclk;
  reg         s_active;
  reg  [2:0]  s_cnt;
  reg  [7:0]  s_tx;
  reg  [7:0]  s_rx;
  reg  [7:0]  next_s_rx;
  reg         s_ovr;
  reg         u_tx_active;
  reg  [3:0]  u_tx_os;
  reg  [3:0]  u_tx_left;
  reg  [12:0] u_tx_sh;
  reg  [12:0] next_frame;
  reg  [8:0]  tdata;
  reg         tpar;
  reg  [1:0]  r_state;
  reg  [3:0]  r_os;
  reg  [3:0]  r_idx;
  reg  [11:0] r_sh;
  reg  [11:0] r_all;
  reg  [8:0]  r_data;
  reg         r_par;
  reg         r_ovr;
  reg         clk_s1;
  reg         clk_s2;
  reg         clk_s3;
  integer     i;
  integer     j;

  wire        tick;
  wire [2:0]  mode_field = serial_mode[2:0];
  wire        is_sync = (mode_field == `DMSP_MODE_SYNC);
  wire        is_uart = (mode_field == `DMSP_MODE_UART7) || (mode_field == `DMSP_MODE_UART8)
                        || (mode_field == `DMSP_MODE_UART9);
  wire        clock_source_external = serial_mode[`DMSP_MR_EXT];
  wire        stop2 = serial_mode[`DMSP_MR_STOP2];
  wire        par_even = serial_mode[`DMSP_MR_EVEN];
  wire        par_en = serial_mode[`DMSP_MR_PAREN];
  wire [3:0]  char_len = (mode_field == `DMSP_MODE_UART7) ? `DMSP_LEN7 :
                         (mode_field == `DMSP_MODE_UART9) ? `DMSP_LEN9 : `DMSP_LEN8;
  wire [3:0]  stop_n = stop2 ? `DMSP_TWO : `DMSP_ONE;
  wire [3:0]  rx_total = char_len + {3'h0, par_en} + stop_n;
  wire [3:0]  frame_len = `DMSP_ONE + rx_total;
  wire        tx_shift_empty = !s_active && !u_tx_active;

  // Address phase and decoded data phase writes
  wire        addr_ok = hsel && hready && htrans[1];
  wire        rd_rxb = addr_ok && !hwrite && (haddr == `DMSP_OFF_RXB);
  wire        wr_txb = d_wr && (d_addr == `DMSP_OFF_TXB);
  wire        wr_brg = d_wr && (d_addr == `DMSP_OFF_BRG);
  wire        wr_mode = d_wr && (d_addr == `DMSP_OFF_MODE);
  wire        wr_ctla = d_wr && (d_addr == `DMSP_OFF_CTLA);
  wire        wr_ctlb = d_wr && (d_addr == `DMSP_OFF_CTLB);
  wire        wr_shared = d_wr && (d_addr == `DMSP_OFF_SHARED);

  // External clock edges, first stage read only by second
  wire        ext_rise = clk_s2 && !clk_s3;
  wire        ext_fall = !clk_s2 && clk_s3;

  // Start needs enable and buffered data; sync receive rides on transmit
  wire        start_ok = transmit_enable && !tx_buffer_empty_flag && !wr_txb;
  wire        s_start = is_sync && !s_active && start_ok;
  wire        u_start = is_uart && !u_tx_active && start_ok;
  wire        s_lead = s_active && (clock_source_external ?
                       (edge_polarity_sel ? ext_rise : ext_fall) :
                       (tick && (sclk != edge_polarity_sel)));
  wire        s_trail = s_active && (clock_source_external ?
                        (edge_polarity_sel ? ext_fall : ext_rise) :
                        (tick && (sclk == edge_polarity_sel)));
  wire        s_done = s_trail && (s_cnt == `DMSP_SYNC_LAST);
  wire        s_ovr_set = s_trail && (s_cnt == `DMSP_SYNC_OVR) && rx_on && rx_done_flag;
  wire        u_tx_done = u_tx_active && tick && (u_tx_os == `DMSP_OS_LAST)
                          && (u_tx_left == 4'h0);
  wire        r_sample = (r_state == R_BITS) && tick && (r_os == `DMSP_OS_LAST);
  wire        r_done = r_sample && (r_idx == rx_total - `DMSP_ONE);
  wire        r_ovr_set = r_sample && (r_idx == rx_total - `DMSP_TWO) && rx_done_flag;
  wire        r_fer = stop2 ? !(serial_in_pin && r_all[rx_total - `DMSP_TWO]) : !serial_in_pin;
  wire        r_per = par_en && (r_par ^ !par_even);
  wire        rx_load = (s_done && rx_on) || r_done;
  wire        ovr_now = s_done ? (s_ovr || s_ovr_set) : (r_ovr || r_ovr_set);
  wire        tx_load = s_start || u_start;
  wire        tx_end = s_done || u_tx_done;

  dmsp_brg u_brg (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .prescale_sel (baud_prescale_sel),
    .use_ext      (is_uart && clock_source_external),
    .ext_edge     (ext_rise),
    .divider      (bit_rate_divider),
    .tick         (tick)
  );

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign serial_out_pin_o = txd;
  assign serial_out_pin_oe = (mode_field != `DMSP_MODE_OFF) && (!txd_open_drain_sel || !txd);
  assign transfer_clock_pin_o = sclk;
  assign transfer_clock_pin_oe = is_sync && !clock_source_external;

  // Read data mux, unmapped and write-only read zero
  always @* begin
    rd_mux = 32'h0000_0000;
    case (haddr)
      `DMSP_OFF_RXB: begin
        rd_mux[8:0] = rx_buffer;
        rd_mux[`DMSP_RB_OVR] = overrun_flag;
        rd_mux[`DMSP_RB_FER] = framing_flag;
        rd_mux[`DMSP_RB_PER] = parity_flag;
        rd_mux[`DMSP_RB_SUM] = overrun_flag || framing_flag || parity_flag;
      end
      `DMSP_OFF_MODE: rd_mux[7:0] = serial_mode;
      `DMSP_OFF_CTLA: begin
        rd_mux[`DMSP_CA_PRE_HI:`DMSP_CA_PRE_LO] = baud_prescale_sel;
        rd_mux[`DMSP_CA_TX_SHIFT_EMPTY] = tx_shift_empty;
        rd_mux[`DMSP_CA_NCH] = txd_open_drain_sel;
        rd_mux[`DMSP_CA_POL] = edge_polarity_sel;
        rd_mux[`DMSP_CA_ORDER] = bit_order_sel;
      end
      `DMSP_OFF_CTLB: begin
        rd_mux[`DMSP_CB_TE] = transmit_enable;
        rd_mux[`DMSP_CB_TI] = tx_buffer_empty_flag;
        rd_mux[`DMSP_CB_RE] = rx_on;
        rd_mux[`DMSP_CB_RI] = rx_done_flag;
      end
      `DMSP_OFF_SHARED: begin
        rd_mux[`DMSP_SH_IRS] = tx_int_source_sel;
        rd_mux[`DMSP_SH_RRM] = continuous_rx_en;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Bus phase tracking and registered read data
  always @(posedge ref_clk) begin
    if (rst) begin
      d_wr   <= 1'b0;
      d_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      d_wr   <= addr_ok && hwrite;
      d_addr <= haddr;
      if (addr_ok && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  // Software written configuration
  always @(posedge ref_clk) begin
    if (rst) begin
      tx_buffer          <= 9'h000;
      bit_rate_divider   <= 8'h00;
      serial_mode        <= 8'h00;
      baud_prescale_sel  <= 2'h0;
      txd_open_drain_sel <= 1'b0;
      edge_polarity_sel  <= 1'b0;
      bit_order_sel      <= 1'b0;
      transmit_enable    <= 1'b0;
      rx_on              <= 1'b0;
      tx_int_source_sel  <= 1'b0;
      continuous_rx_en   <= 1'b0;
    end else begin
      if (wr_txb) begin
        tx_buffer <= hwdata[8:0];
      end
      if (wr_brg) begin
        bit_rate_divider <= hwdata[7:0];
      end
      if (wr_mode) begin
        serial_mode <= hwdata[7:0];
      end
      if (wr_ctla) begin
        baud_prescale_sel  <= hwdata[`DMSP_CA_PRE_HI:`DMSP_CA_PRE_LO];
        txd_open_drain_sel <= hwdata[`DMSP_CA_NCH];
        edge_polarity_sel  <= hwdata[`DMSP_CA_POL];
        bit_order_sel      <= hwdata[`DMSP_CA_ORDER];
      end
      if (wr_ctlb) begin
        transmit_enable <= hwdata[`DMSP_CB_TE];
        rx_on           <= hwdata[`DMSP_CB_RE];
      end
      if (wr_shared) begin
        tx_int_source_sel <= hwdata[`DMSP_SH_IRS];
        continuous_rx_en  <= hwdata[`DMSP_SH_RRM];
      end
    end
  end

  // Status flags, receive buffer and interrupt pulses; set beats clear
  always @(posedge ref_clk) begin
    if (rst) begin
      rx_buffer            <= 9'h000;
      tx_buffer_empty_flag <= 1'b1;
      rx_done_flag         <= 1'b0;
      overrun_flag         <= 1'b0;
      framing_flag         <= 1'b0;
      parity_flag          <= 1'b0;
      tx_int               <= 1'b0;
      rx_int               <= 1'b0;
    end else begin
      tx_int <= (tx_load && !tx_int_source_sel) || (tx_end && tx_int_source_sel);
      rx_int <= rx_load && !ovr_now;
      if (tx_load) begin
        tx_buffer_empty_flag <= 1'b1;
      end else if (wr_txb) begin
        tx_buffer_empty_flag <= 1'b0;
      end else if (rd_rxb && continuous_rx_en && is_sync) begin
        tx_buffer_empty_flag <= 1'b0;
      end
      if (rx_load) begin
        rx_buffer    <= s_done ? {1'b0, next_s_rx} : r_data;
        rx_done_flag <= 1'b1;
      end else if (rd_rxb) begin
        rx_done_flag <= 1'b0;
      end
      if (s_ovr_set || r_ovr_set) begin
        overrun_flag <= 1'b1;
      end else if (!rx_on) begin
        overrun_flag <= 1'b0;
      end
      if (r_done && r_fer) begin
        framing_flag <= 1'b1;
      end else if (!rx_on) begin
        framing_flag <= 1'b0;
      end
      if (r_done && r_per) begin
        parity_flag <= 1'b1;
      end else if (!rx_on) begin
        parity_flag <= 1'b0;
      end
    end
  end

  // Transmit frame assembly: start, data, parity, stop ones
  always @* begin
    tdata = tx_buffer;
    if (bit_order_sel && (char_len == `DMSP_LEN8)) begin
      for (i = 0; i < 8; i = i + 1) begin
        tdata[i] = tx_buffer[7 - i];
      end
    end
    tpar = !par_even;
    next_frame = 13'h1FFF;
    next_frame[0] = 1'b0;
    for (i = 0; i < 9; i = i + 1) begin
      if (i < char_len) begin
        next_frame[i + 1] = tdata[i];
        tpar = tpar ^ tdata[i];
      end
    end
    if (par_en) begin
      next_frame[char_len + 4'h1] = tpar;
    end
  end

  // Receive side assembly of sync byte and UART character
  always @* begin
    next_s_rx = bit_order_sel ? {s_rx[6:0], serial_in_pin} : {serial_in_pin, s_rx[7:1]};
    r_all = r_sh;
    r_all[r_idx] = serial_in_pin;
    r_data = 9'h000;
    r_par = 1'b0;
    for (j = 0; j < 9; j = j + 1) begin
      if (j < char_len) begin
        r_data[j] = r_all[j];
        r_par = r_par ^ r_all[j];
      end
    end
    r_par = r_par ^ r_all[char_len];
    if (bit_order_sel && (char_len == `DMSP_LEN8)) begin
      for (j = 0; j < 8; j = j + 1) begin
        r_data[j] = r_all[7 - j];
      end
    end
  end

  // External clock synchroniser
  always @(posedge ref_clk) begin
    if (rst) begin
      clk_s1 <= 1'b1;
      clk_s2 <= 1'b1;
      clk_s3 <= 1'b1;
    end else begin
      clk_s1 <= transfer_clock_pin_i;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
    end
  end

  // Transmit engines for both modes, one output flop
  always @(posedge ref_clk) begin
    if (rst) begin
      txd         <= 1'b1;
      sclk        <= 1'b1;
      s_active    <= 1'b0;
      s_cnt       <= 3'h0;
      s_tx        <= 8'h00;
      s_rx        <= 8'h00;
      s_ovr       <= 1'b0;
      u_tx_active <= 1'b0;
      u_tx_os     <= 4'h0;
      u_tx_left   <= 4'h0;
      u_tx_sh     <= 13'h1FFF;
    end else begin
      // New mode selected: line returns high until the first transfer
      if (wr_mode && (hwdata[2:0] != mode_field)) begin
        txd <= 1'b1;
      end
      if (!is_sync || clock_source_external || !s_active) begin
        sclk <= !edge_polarity_sel;
      end else if (tick) begin
        sclk <= !sclk;
      end
      if (s_start) begin
        s_active <= 1'b1;
        s_cnt    <= 3'h0;
        s_tx     <= tx_buffer[7:0];
        s_ovr    <= 1'b0;
      end
      if (s_lead) begin
        txd  <= bit_order_sel ? s_tx[7] : s_tx[0];
        s_tx <= bit_order_sel ? {s_tx[6:0], 1'b0} : {1'b0, s_tx[7:1]};
      end
      if (s_trail) begin
        s_rx  <= next_s_rx;
        s_cnt <= s_cnt + 3'h1;
        if (s_ovr_set) begin
          s_ovr <= 1'b1;
        end
        if (s_cnt == `DMSP_SYNC_LAST) begin
          s_active <= 1'b0;
        end
      end
      if (!is_sync) begin
        s_active <= 1'b0;
      end
      if (u_start) begin
        u_tx_active <= 1'b1;
        u_tx_os     <= 4'h0;
        u_tx_left   <= frame_len - `DMSP_ONE;
        u_tx_sh     <= next_frame;
        txd         <= 1'b0;
      end else if (u_tx_active && tick) begin
        u_tx_os <= u_tx_os + 4'h1;
        if (u_tx_os == `DMSP_OS_LAST) begin
          if (u_tx_left == 4'h0) begin
            u_tx_active <= 1'b0;
            txd         <= 1'b1;
          end else begin
            u_tx_left <= u_tx_left - 4'h1;
            u_tx_sh   <= {1'b1, u_tx_sh[12:1]};
            txd       <= u_tx_sh[1];
          end
        end
      end
      if (!is_uart) begin
        u_tx_active <= 1'b0;
      end
    end
  end

  // UART receiver with 16x oversampling
  always @(posedge ref_clk) begin
    if (rst) begin
      r_state <= R_IDLE;
      r_os    <= 4'h0;
      r_idx   <= 4'h0;
      r_sh    <= 12'h000;
      r_ovr   <= 1'b0;
    end else begin
      case (r_state)
        R_IDLE: begin
          r_os  <= 4'h0;
          r_ovr <= 1'b0;
          if (is_uart && rx_on && !serial_in_pin) begin
            r_state <= R_START;
          end
        end
        R_START: begin
          if (tick) begin
            r_os <= r_os + 4'h1;
            if (r_os == `DMSP_OS_MID) begin
              r_os  <= 4'h0;
              r_idx <= 4'h0;
              r_state <= serial_in_pin ? R_IDLE : R_BITS;
            end
          end
        end
        R_BITS: begin
          if (tick) begin
            r_os <= r_os + 4'h1;
          end
          if (r_sample) begin
            r_sh  <= r_all;
            r_idx <= r_idx + 4'h1;
            if (r_ovr_set) begin
              r_ovr <= 1'b1;
            end
            if (r_done) begin
              r_state <= R_IDLE;
            end
          end
        end
        default: r_state <= R_IDLE;
      endcase
      if (!is_uart || !rx_on) begin
        r_state <= R_IDLE;
      end
    end
  end
endmodule // dmsp_top

// ==== testbench/dmsp_monitor.sv ====
// Checker on the serial port's bus and pin behaviour
`timescale 1ns/10ps
module dmsp_monitor (
  input wire        ref_clk,
  input wire        rst,
  input wire        hsel,
  input wire [7:0]  haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hwdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire [31:0] hrdata,
  input wire        serial_in_pin,
  input wire        serial_out_pin_o,
  input wire        serial_out_pin_oe,
  input wire        transfer_clock_pin_i,
  input wire        transfer_clock_pin_o,
  input wire        transfer_clock_pin_oe,
  input wire        tx_int,
  input wire        rx_int
);
  wire      take = hsel && hready && htrans[1];
  reg [3:0] mode;
  reg       wr_mode;
  reg       rd_unm;
  // Mirror of mode and clock source, plus unmapped read marker
  always @(posedge ref_clk) begin
    wr_mode <= !rst && take && hwrite && haddr == 8'h0C;
    rd_unm  <= !rst && take && !hwrite && haddr > 8'h18;
    if (rst) mode <= 4'h0;
    else if (wr_mode) mode <= hwdata[3:0];
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // A falling edge on the UART line in UART modes, then eight cycles low
  sequence s_tx_fall;
    mode[2] && $fell(serial_out_pin_o);
  endsequence
  sequence s_bit_low;
    (!serial_out_pin_o) [*8];
  endsequence
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_unmapped_zero: assert property (rd_unm |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_clk_pin_dir: assert property (transfer_clock_pin_oe == (mode == 4'h1))
    else $error("clock pin direction wrong");
  a_off_float: assert property (mode[2:0] == 3'h0 |-> !serial_out_pin_oe)
    else $error("output driven while off");
  a_reset_idle: assert property (disable iff (1'b0) rst |=>
    serial_out_pin_o && !serial_out_pin_oe && !tx_int && !rx_int)
    else $error("outputs not idle after reset");
  a_tx_pulse: assert property (tx_int |=> !tx_int)
    else $error("tx_int longer than one cycle");
  a_rx_pulse: assert property (rx_int |=> !rx_int)
    else $error("rx_int longer than one cycle");
  a_uart_bitlen: assert property (s_tx_fall |-> s_bit_low)
    else $error("uart bit too short");
endmodule // dmsp_monitor

bind dmsp_top dmsp_monitor u_mon (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hresp(hresp),
  .hreadyout(hreadyout), .hrdata(hrdata), .serial_in_pin(serial_in_pin),
  .serial_out_pin_o(serial_out_pin_o), .serial_out_pin_oe(serial_out_pin_oe),
  .transfer_clock_pin_i(transfer_clock_pin_i), .transfer_clock_pin_o(transfer_clock_pin_o),
  .transfer_clock_pin_oe(transfer_clock_pin_oe), .tx_int(tx_int), .rx_int(rx_int));

// ==== testbench/dmsp_peer.sv ====
// UART peer that sends 8-bit even-parity frames to the port
`timescale 1ns/10ps
module dmsp_peer #(
  parameter BIT = 16
) (
  input  wire ref_clk,
  output reg  rxd
);
  initial rxd = 1'b1;
  // One frame: start, data LSB first, parity, stop; errors on request
  task send(input [7:0] d, input pb, input sb);
    integer   i;
    reg [10:0] f;
    begin
      f = {~sb, ^d ^ pb, d, 1'b0};
      for (i = 0; i < 11; i = i + 1) begin
        rxd <= f[i];
        repeat (BIT) @(posedge ref_clk);
      end
      rxd <= 1'b1;
    end
  endtask
endmodule // dmsp_peer

// ==== testbench/test_dmsp_top.sv ====
// Self-checking bench for the dual mode serial port
`timescale 1ns/10ps
module test_dmsp_top;
  reg         ref_clk;
  reg         rst;
  reg         hsel;
  reg  [7:0]  haddr;
  reg  [1:0]  htrans;
  reg         hwrite;
  reg         eck;
  reg  [31:0] hwdata;
  wire        hreadyout;
  wire        hresp;
  wire [31:0] hrdata;
  wire        sin;
  wire        sout;
  wire        clk_o;
  wire        tx_int;
  wire        rx_int;
  integer     fails;
  integer     check_count;
  integer     seed;
  integer     txn;
  integer     rxn;
  integer     ck;
  integer     k;
  reg  [7:0]  sh;
  reg  [7:0]  d;
  reg  [10:0] f;
  reg  [31:0] r;
  reg  [31:0] e;
  reg  [7:0]  q[$];
  dmsp_top u_dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .serial_in_pin(sin),
    .serial_out_pin_o(sout), .serial_out_pin_oe(), .transfer_clock_pin_i(eck),
    .transfer_clock_pin_o(clk_o), .transfer_clock_pin_oe(), .tx_int(tx_int),
    .rx_int(rx_int));
  dmsp_peer u_peer (.ref_clk(ref_clk), .rxd(sin));
  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Interrupt pulse counters
  always @(posedge ref_clk) begin
    txn <= rst ? 0 : txn + tx_int;
    rxn <= rst ? 0 : rxn + rx_int;
  end
  // Synchronous capture on rising transfer clock
  always @(posedge clk_o) begin
    sh = {sh[6:0], sout};
    ck = ck + 1;
  end
  // One AHB-Lite single transfer
  task bus(input w, input [7:0] a, input [31:0] wd, output [31:0] rd);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
    end
  endtask
  // Compare and count
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Sample one 11-bit UART frame at mid-bit
  task frame(output [10:0] fr);
    integer i;
    begin
      @(negedge sout);
      repeat (8) @(negedge ref_clk);
      for (i = 0; i < 11; i = i + 1) begin
        fr[i] = sout;
        if (i < 10) repeat (16) @(negedge ref_clk);
      end
      @(posedge ref_clk);
    end
  endtask
  // Counts and verdict
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails = fails + 1;
    give_verdict;
  end
  // Main sequence
  initial begin
    fails = 0;
    check_count = 0;
    seed = 9134;
    ck = 0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    eck = 1'b1;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    bus(0, 8'h14, 0, r);
    chk(r, 32'h2);
    bus(0, 8'h1C, 0, r);
    chk(r, 32'h0);
    bus(1, 8'h0C, 32'h01, r);
    bus(1, 8'h10, 32'h80, r);
    bus(1, 8'h14, 32'h05, r);
    ck = 0;
    d = $random(seed);
    bus(1, 8'h00, d, r);
    while (ck < 8) @(posedge ref_clk);
    chk(sh, d);
    repeat (4) @(posedge ref_clk);
    bus(0, 8'h04, 0, r);
    chk(r, 32'hFF);
    bus(1, 8'h0C, 32'h09, r);
    d = $random(seed);
    bus(1, 8'h00, d, r);
    for (k = 0; k < 8; k = k + 1) begin
      repeat (4) @(posedge ref_clk);
      eck <= 1'b0;
      repeat (4) @(posedge ref_clk);
      e = {e[30:0], sout};
      eck <= 1'b1;
    end
    repeat (6) @(posedge ref_clk);
    chk(e[7:0], d);
    bus(0, 8'h04, 0, r);
    chk(r, 32'hFF);
    $display("sync transfer test done");
    bus(1, 8'h0C, 32'h65, r);
    bus(1, 8'h10, 32'h00, r);
    bus(1, 8'h08, 32'h00, r);
    for (k = 0; k < 2; k = k + 1) begin
      bus(1, 8'h18, k, r);
      d = $random(seed);
      q.push_back(d);
      e = txn;
      bus(1, 8'h00, d, r);
      frame(f);
      chk(txn - e, 1 - k);
      d = q.pop_front();
      chk(f, {1'b1, ^d, d, 1'b0});
      repeat (20) @(posedge ref_clk);
      chk(txn - e, 1);
    end
    $display("uart transmit test done");
    for (k = 0; k < 4; k = k + 1) begin
      bus(1, 8'h14, 32'h01, r);
      bus(1, 8'h14, 32'h05, r);
      d = $random(seed);
      e = rxn;
      if (k == 3) u_peer.send(~d, 1'b0, 1'b0);
      u_peer.send(d, k == 1, k == 2);
      repeat (20) @(posedge ref_clk);
      chk(rxn - e, 1);
      bus(0, 8'h04, 0, r);
      e = (k == 0) ? 32'h0 : (k == 1) ? 32'hC000 : (k == 2) ? 32'hA000 : 32'h9000;
      if (k != 3) e = e | d;
      chk(r & ((k == 3) ? 32'hF000 : 32'hFFFF), e);
    end
    bus(0, 8'h14, 0, r);
    chk(r, 32'h7);
    $display("uart receive test done");
    give_verdict;
  end
endmodule // test_dmsp_top
